/* mrim_pkg.sv */
// Constants for the MAC receive interrupt mask and status block.
// Notes on behaviour
// RQ1: Receive masked status bit n shows channel n.
// RQ2: Enable-set write of one enables channel n.
// RQ3: Enable-clear write of one disables channel n.
// RQ4: Unused upper bits read zero, ignore writes.
// RQ5: MAC raw status: host fault bit1, counter bit0.
// RQ6: MAC masked status: same bits after enables.
// RQ7: MAC enable-set write of one enables source.
// RQ8: MAC enable-clear write of one disables source.
// RQ9: Low-byte address write disables that channel.
// RQ10: High address write re-enables if filter enabled.
// RQ11: Software writes high address after low byte.
// RQ12: Masked equals raw AND enable; irq on any.
// RQ13: Summary vector carries receive pending in 15:8.
// RQ14: Receive raw status shows pending before masking.
package mrim_pkg;
  // ==========================================================
  // Widths
  localparam int RX_CHANS = 8;
  localparam int MAC_SRCS = 2;
  localparam int EVT_W    = 10;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int FILT_W   = 3;
  localparam int CHAN_IDX_W = 3;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_RX_RAW      = 8'h00;
  localparam logic [7:0] OFS_RX_MASKED   = 8'h04;
  localparam logic [7:0] OFS_RX_EN_SET   = 8'h08;
  localparam logic [7:0] OFS_RX_EN_CLR   = 8'h0C;
  localparam logic [7:0] OFS_MAC_RAW     = 8'h10;
  localparam logic [7:0] OFS_MAC_MASKED  = 8'h14;
  localparam logic [7:0] OFS_MAC_EN_SET  = 8'h18;
  localparam logic [7:0] OFS_MAC_EN_CLR  = 8'h1C;
  localparam logic [7:0] OFS_SUMMARY     = 8'h20;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'h24;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h28;
  localparam logic [7:0] OFS_FILTER_CTRL = 8'h2C;
  localparam logic [7:0] OFS_ADDR_HIGH   = 8'h30;
  localparam logic [7:0] OFS_ADDR_LOW    = 8'h40;
  // ==========================================================
  // Field positions
  localparam int MAC_COUNTER_BIT = 0;
  localparam int MAC_HOST_BIT    = 1;
  localparam int SUM_RX_LSB      = 8;
  localparam int SUM_COUNTER_BIT = 16;
  localparam int SUM_HOST_BIT    = 17;
  localparam int EVT_MAC_LSB     = 8;
  localparam int ADDR_GROUP_BIT  = 0;
  // ==========================================================
  // Reset values
  localparam logic [RX_CHANS-1:0] RX_EN_RST   = 8'h00;
  localparam logic [MAC_SRCS-1:0] MAC_EN_RST  = 2'h0;
  localparam logic [EVT_W-1:0]    EVT_RST     = 10'h000;
  localparam logic [FILT_W-1:0]   FILT_RST    = 3'h0;
  localparam logic [RX_CHANS-1:0] CHAN_EN_RST = 8'h00;
  localparam logic [7:0]          LOW_RST     = 8'h00;
  localparam logic [DATA_W-1:0]   HIGH_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0]   RD_RST      = 32'h0000_0000;
endpackage : mrim_pkg

/* mrim_bank_if.sv */
// Set/clear strobes and enable state of one enable bank.
`timescale 1ns/100ps
interface mrim_bank_if #(parameter int N = 8);
  logic [N-1:0] set_bits;
  logic [N-1:0] clr_bits;
  logic [N-1:0] enable;
  modport ctrl (output set_bits, output clr_bits, input enable);
  modport bank (input set_bits, input clr_bits, output enable);
endinterface : mrim_bank_if

/* mrim_enable_bank.sv */
// Interrupt enable bank with write-one-to-set and write-one-to-clear.
`timescale 1ns/100ps
module mrim_enable_bank #(
  parameter int N = 8
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  mrim_bank_if.bank bus
);
  logic [N-1:0] enable_reg;
  logic [N-1:0] enable_next;

  // ==========================================================
  // Per-bit update
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set wins if both ever arrive, so an enable is never lost.
      assign enable_next[i] = bus.set_bits[i] |
                              (enable_reg[i] & ~bus.clr_bits[i]);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign bus.enable = enable_reg;
endmodule : mrim_enable_bank

/* mrim_addr_chan.sv */
// Address channel store and enable control for the receive filter.
`timescale 1ns/100ps
module mrim_addr_chan (
  input  wire logic                            core_clk,
  input  wire logic                            reset_n,
  input  wire logic                            low_wr_stb,
  input  wire logic [mrim_pkg::CHAN_IDX_W-1:0] low_chan,
  input  wire logic                            high_wr_stb,
  input  wire logic [mrim_pkg::DATA_W-1:0]     wr_data,
  input  wire logic                            filter_any,
  output logic      [mrim_pkg::RX_CHANS-1:0]   chan_enable,
  output logic      [mrim_pkg::RX_CHANS*8-1:0] low_bytes,
  output logic      [mrim_pkg::DATA_W-1:0]     high_word
);
  import mrim_pkg::*;

  logic [7:0]          low_byte_mem [0:RX_CHANS-1];
  logic [RX_CHANS-1:0] chan_en_reg;
  logic [RX_CHANS-1:0] chan_en_next;
  logic [RX_CHANS-1:0] rearm_reg;
  logic [RX_CHANS-1:0] rearm_next;
  logic [RX_CHANS-1:0] low_hit;
  logic [DATA_W-1:0]   high_reg;
  logic                high_ok;

  assign high_ok = high_wr_stb & filter_any;

  // ==========================================================
  // Per-channel enable
  genvar i;
  generate
    for (i = 0; i < RX_CHANS; i++) begin : g_chan
      assign low_hit[i] = low_wr_stb &&
                          (low_chan == CHAN_IDX_W'(i));
      // A channel waits for the high word so a half-written
      // address never matches frames.
      assign rearm_next[i] = low_hit[i] | (rearm_reg[i] & ~high_ok);
      // RQ9 RQ10 disable and re-enable
      assign chan_en_next[i] = ~low_hit[i] &
                               (chan_en_reg[i] |
                                (rearm_reg[i] & high_ok));
      assign low_bytes[i*8 +: 8] = low_byte_mem[i];
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          low_byte_mem[i] <= LOW_RST;
        end else if (low_hit[i]) begin
          low_byte_mem[i] <= wr_data[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chan_en_reg <= CHAN_EN_RST;
      rearm_reg   <= CHAN_EN_RST;
      high_reg    <= HIGH_RST;
    end else begin
      chan_en_reg <= chan_en_next;
      rearm_reg   <= rearm_next;
      if (high_wr_stb) begin
        // The group bit of a specific address is always zero.
        high_reg <= {wr_data[DATA_W-1:1], 1'b0};
      end
    end
  end

  assign chan_enable = chan_en_reg;
  assign high_word   = high_reg;

  // ==========================================================
  // Checks
  property p_low_disable;
    @(posedge core_clk) disable iff (!reset_n)
    low_wr_stb |=> !chan_en_reg[$past(low_chan)];
  endproperty
  a_low_disable: assert property (p_low_disable) // RQ9
    else $error("Low byte write left channel enabled.");

  property p_high_enable;
    @(posedge core_clk) disable iff (!reset_n)
    high_ok |=> chan_en_reg == ($past(chan_en_reg) | $past(rearm_reg));
  endproperty
  a_high_enable: assert property (p_high_enable) // RQ10
    else $error("High write did not re-enable channels.");

  property p_high_blocked;
    @(posedge core_clk) disable iff (!reset_n)
    (high_wr_stb && !filter_any) |=> $stable(chan_en_reg);
  endproperty
  a_high_blocked: assert property (p_high_blocked) // RQ10
    else $error("Channel enabled with receive filter off.");
endmodule : mrim_addr_chan

/* mrim_top.sv */
// Receive and MAC interrupt status, enables and address channel control.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
module mrim_top (
  input  wire logic                           core_clk,
  input  wire logic                           reset_n,
  input  wire logic [mrim_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [mrim_pkg::DATA_W-1:0]    reg_wr_data,
  input  wire logic                           reg_wr_stb,
  input  wire logic                           reg_rd_stb,
  output logic      [mrim_pkg::DATA_W-1:0]    reg_rd_data,
  input  wire logic [mrim_pkg::RX_CHANS-1:0]  rx_pending_vector,
  input  wire logic                           host_fault_irq,
  input  wire logic                           counter_irq,
  output logic                                mac_irq,
  output logic      [mrim_pkg::FILT_W-1:0]    rx_filter_enable,
  output logic      [mrim_pkg::RX_CHANS-1:0]  addr_chan_enable,
  output logic      [mrim_pkg::RX_CHANS*8-1:0] addr_low_byte_chan,
  output logic      [mrim_pkg::DATA_W-1:0]    addr_high_word
);
  import mrim_pkg::*;

  // ==========================================================
  // Address decode
  logic hit_rx_raw;
  logic hit_rx_masked;
  logic hit_rx_set;
  logic hit_rx_clr;
  logic hit_mac_raw;
  logic hit_mac_masked;
  logic hit_mac_set;
  logic hit_mac_clr;
  logic hit_summary;
  logic hit_evt_status;
  logic hit_evt_mask;
  logic hit_filter;
  logic hit_high;
  logic hit_low;

  assign hit_rx_raw     = (reg_addr == OFS_RX_RAW);
  assign hit_rx_masked  = (reg_addr == OFS_RX_MASKED);
  assign hit_rx_set     = (reg_addr == OFS_RX_EN_SET);
  assign hit_rx_clr     = (reg_addr == OFS_RX_EN_CLR);
  assign hit_mac_raw    = (reg_addr == OFS_MAC_RAW);
  assign hit_mac_masked = (reg_addr == OFS_MAC_MASKED);
  assign hit_mac_set    = (reg_addr == OFS_MAC_EN_SET);
  assign hit_mac_clr    = (reg_addr == OFS_MAC_EN_CLR);
  assign hit_summary    = (reg_addr == OFS_SUMMARY);
  assign hit_evt_status = (reg_addr == OFS_EVT_STATUS);
  assign hit_evt_mask   = (reg_addr == OFS_EVT_MASK);
  assign hit_filter     = (reg_addr == OFS_FILTER_CTRL);
  assign hit_high       = (reg_addr == OFS_ADDR_HIGH);
  // Eight aligned words from the low-byte base, index in bits 4:2.
  assign hit_low        = (reg_addr[7:5] == OFS_ADDR_LOW[7:5]) &&
                          (reg_addr[1:0] == 2'h0);

  // ==========================================================
  // Enable banks
  mrim_bank_if #(.N(RX_CHANS)) rx_bank_if ();
  mrim_bank_if #(.N(MAC_SRCS)) mac_bank_if ();

  mrim_enable_bank #(.N(RX_CHANS)) u_rx_bank (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bus      (rx_bank_if.bank)
  );

  mrim_enable_bank #(.N(MAC_SRCS)) u_mac_bank (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bus      (mac_bank_if.bank)
  );

  logic [RX_CHANS-1:0] rx_en;
  logic [MAC_SRCS-1:0] mac_en;

  // RQ2 RQ4 receive enable set
  assign rx_bank_if.set_bits  = (reg_wr_stb && hit_rx_set) ?
                                reg_wr_data[RX_CHANS-1:0] : '0;
  // RQ3 RQ4 receive enable clear
  assign rx_bank_if.clr_bits  = (reg_wr_stb && hit_rx_clr) ?
                                reg_wr_data[RX_CHANS-1:0] : '0;
  // RQ7 RQ4 MAC enable set
  assign mac_bank_if.set_bits = (reg_wr_stb && hit_mac_set) ?
                                reg_wr_data[MAC_SRCS-1:0] : '0;
  // RQ8 RQ4 MAC enable clear
  assign mac_bank_if.clr_bits = (reg_wr_stb && hit_mac_clr) ?
                                reg_wr_data[MAC_SRCS-1:0] : '0;
  assign rx_en  = rx_bank_if.enable;
  assign mac_en = mac_bank_if.enable;

  // ==========================================================
  // Raw and masked status
  logic [RX_CHANS-1:0] rx_raw;
  logic [RX_CHANS-1:0] rx_masked_w;
  logic [MAC_SRCS-1:0] mac_raw;
  logic [MAC_SRCS-1:0] mac_masked_w;
  logic [DATA_W-1:0]   summary_w;

  // RQ14 raw receive view
  assign rx_raw = rx_pending_vector;
  // RQ5 raw MAC view
  assign mac_raw[MAC_HOST_BIT]    = host_fault_irq;
  assign mac_raw[MAC_COUNTER_BIT] = counter_irq;
  // RQ12 RQ1 RQ6 masking
  assign rx_masked_w  = rx_raw & rx_en;
  assign mac_masked_w = mac_raw & mac_en;

  // RQ13 summary layout
  assign summary_w = (DATA_W'(rx_masked_w) << SUM_RX_LSB) |
    (DATA_W'(mac_masked_w[MAC_COUNTER_BIT]) << SUM_COUNTER_BIT) |
    (DATA_W'(mac_masked_w[MAC_HOST_BIT]) << SUM_HOST_BIT);

  // ==========================================================
  // Sticky events, cleared by reading the event status
  logic [EVT_W-1:0] evt_level;
  logic [EVT_W-1:0] evt_prev_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [EVT_W-1:0] evt_next;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_clr;

  assign evt_level = {mac_raw, rx_raw};
  assign evt_clr   = (reg_rd_stb && hit_evt_status) ? '1 : '0;
  // A rising source in the read cycle survives the clear.
  assign evt_next  = (evt_level & ~evt_prev_reg) |
                     (evt_reg & ~evt_clr);

  // ==========================================================
  // Address channels
  logic [FILT_W-1:0] filter_reg;

  mrim_addr_chan u_addr_chan (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .low_wr_stb  (reg_wr_stb && hit_low),
    .low_chan    (reg_addr[4:2]),
    .high_wr_stb (reg_wr_stb && hit_high),
    .wr_data     (reg_wr_data),
    .filter_any  (|filter_reg),
    .chan_enable (addr_chan_enable),
    .low_bytes   (addr_low_byte_chan),
    .high_word   (addr_high_word)
  );

  // ==========================================================
  // Read selection; enable-set and enable-clear read the enables
  logic [DATA_W-1:0] rd_mux;
  logic [7:0]        low_sel;
  logic              irq_next;
  logic              irq_reg;
  logic [DATA_W-1:0] rd_reg;

  assign low_sel = addr_low_byte_chan[reg_addr[4:2]*8 +: 8];

  // RQ4 unused bits zero
  assign rd_mux =
    ({DATA_W{hit_rx_raw}}     & DATA_W'(rx_raw)) |
    ({DATA_W{hit_rx_masked}}  & DATA_W'(rx_masked_w)) |
    ({DATA_W{hit_rx_set | hit_rx_clr}}   & DATA_W'(rx_en)) |
    ({DATA_W{hit_mac_raw}}    & DATA_W'(mac_raw)) |
    ({DATA_W{hit_mac_masked}} & DATA_W'(mac_masked_w)) |
    ({DATA_W{hit_mac_set | hit_mac_clr}} & DATA_W'(mac_en)) |
    ({DATA_W{hit_summary}}    & summary_w) |
    ({DATA_W{hit_evt_status}} & DATA_W'(evt_reg)) |
    ({DATA_W{hit_evt_mask}}   & DATA_W'(evt_mask_reg)) |
    ({DATA_W{hit_filter}}     & DATA_W'(filter_reg)) |
    ({DATA_W{hit_high}}       & addr_high_word) |
    ({DATA_W{hit_low}}        & DATA_W'(low_sel));

  // RQ12 interrupt output
  assign irq_next = (|rx_masked_w) | (|mac_masked_w) |
                    (|(evt_reg & evt_mask_reg));

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      evt_prev_reg <= EVT_RST;
      evt_reg      <= EVT_RST;
      evt_mask_reg <= EVT_RST;
      filter_reg   <= FILT_RST;
      irq_reg      <= 1'b0;
      rd_reg       <= RD_RST;
    end else begin
      evt_prev_reg <= evt_level;
      evt_reg      <= evt_next;
      if (reg_wr_stb && hit_evt_mask) begin
        evt_mask_reg <= reg_wr_data[EVT_W-1:0];
      end
      if (reg_wr_stb && hit_filter) begin
        filter_reg <= reg_wr_data[FILT_W-1:0];
      end
      irq_reg <= irq_next;
      // Read data stand for one cycle only, zero otherwise.
      rd_reg  <= reg_rd_stb ? rd_mux : RD_RST;
    end
  end

  assign reg_rd_data      = rd_reg;
  assign mac_irq          = irq_reg;
  assign rx_filter_enable = filter_reg;

  // ==========================================================
  // Checks
  property p_rx_masked_rd;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && hit_rx_masked) |=>
      reg_rd_data == DATA_W'($past(rx_pending_vector) & $past(rx_en));
  endproperty
  a_rx_masked_rd: assert property (p_rx_masked_rd) // RQ1
    else $error("Receive masked status read wrong.");

  property p_rx_set;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_wr_stb && hit_rx_set) |=>
      rx_en == ($past(rx_en) | $past(reg_wr_data[RX_CHANS-1:0]));
  endproperty
  a_rx_set: assert property (p_rx_set) // RQ2
    else $error("Receive enable set wrong.");

  property p_rx_clr;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_wr_stb && hit_rx_clr) |=>
      rx_en == ($past(rx_en) & ~$past(reg_wr_data[RX_CHANS-1:0]));
  endproperty
  a_rx_clr: assert property (p_rx_clr) // RQ3
    else $error("Receive enable clear wrong.");

  property p_rx_reserved;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && (hit_rx_raw || hit_rx_masked || hit_rx_set)) |=>
      reg_rd_data[DATA_W-1:RX_CHANS] == '0;
  endproperty
  a_rx_reserved: assert property (p_rx_reserved) // RQ4
    else $error("Receive reserved bits not zero.");

  property p_mac_reserved;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && (hit_mac_raw || hit_mac_masked || hit_mac_clr)) |=>
      reg_rd_data[DATA_W-1:MAC_SRCS] == '0;
  endproperty
  a_mac_reserved: assert property (p_mac_reserved) // RQ4
    else $error("MAC reserved bits not zero.");

  property p_mac_raw_rd;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && hit_mac_raw) |=>
      reg_rd_data[1:0] == {$past(host_fault_irq), $past(counter_irq)};
  endproperty
  a_mac_raw_rd: assert property (p_mac_raw_rd) // RQ5
    else $error("MAC raw status read wrong.");

  property p_mac_masked_rd;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && hit_mac_masked) |=> reg_rd_data[1:0] ==
      ({$past(host_fault_irq), $past(counter_irq)} & $past(mac_en));
  endproperty
  a_mac_masked_rd: assert property (p_mac_masked_rd) // RQ6
    else $error("MAC masked status read wrong.");

  property p_mac_set;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_wr_stb && hit_mac_set) |=>
      mac_en == ($past(mac_en) | $past(reg_wr_data[1:0]));
  endproperty
  a_mac_set: assert property (p_mac_set) // RQ7
    else $error("MAC enable set wrong.");

  property p_mac_clr;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_wr_stb && hit_mac_clr) |=>
      mac_en == ($past(mac_en) & ~$past(reg_wr_data[1:0]));
  endproperty
  a_mac_clr: assert property (p_mac_clr) // RQ8
    else $error("MAC enable clear wrong.");

  property p_irq_follows;
    @(posedge core_clk) disable iff (!reset_n)
    ((|(rx_pending_vector & rx_en)) || (|mac_masked_w)) |=> mac_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // RQ12
    else $error("Interrupt missing for masked source.");

  property p_summary_rd;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && hit_summary) |=>
      reg_rd_data[17:8] == {$past(host_fault_irq) & $past(mac_en[1]),
                            $past(counter_irq) & $past(mac_en[0]),
                            $past(rx_pending_vector) & $past(rx_en)};
  endproperty
  a_summary_rd: assert property (p_summary_rd) // RQ13
    else $error("Summary receive field wrong.");

  property p_rx_raw_rd;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd_stb && hit_rx_raw) |=>
      reg_rd_data[RX_CHANS-1:0] == $past(rx_pending_vector);
  endproperty
  a_rx_raw_rd: assert property (p_rx_raw_rd) // RQ14
    else $error("Receive raw status read wrong.");
endmodule : mrim_top

/* tb_mac_rx_interrupt_mask_status.sv */
// Self-checking testbench for the receive and MAC interrupt block.
`timescale 1ns/100ps
module tb_mac_rx_interrupt_mask_status;
  import mrim_pkg::*;
  // ==========================================================
  // Clock, reset and design hookup
  logic                  core_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [ADDR_W-1:0]     reg_addr = 8'h00;
  logic [DATA_W-1:0]     reg_wr_data = 32'h0000_0000;
  logic                  reg_wr_stb = 1'b0;
  logic                  reg_rd_stb = 1'b0;
  logic [DATA_W-1:0]     reg_rd_data;
  logic [RX_CHANS-1:0]   rx_pending_vector = 8'h00;
  logic                  host_fault_irq = 1'b0;
  logic                  counter_irq = 1'b0;
  logic                  mac_irq;
  logic [FILT_W-1:0]     rx_filter_enable;
  logic [RX_CHANS-1:0]   addr_chan_enable;
  logic [RX_CHANS*8-1:0] addr_low_byte_chan;
  logic [DATA_W-1:0]     addr_high_word;
  int                    n_mismatch = 0;
  int                    n_tests = 0;

  always #25 core_clk = ~core_clk;

  mrim_top u_dut (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .reg_addr           (reg_addr),
    .reg_wr_data        (reg_wr_data),
    .reg_wr_stb         (reg_wr_stb),
    .reg_rd_stb         (reg_rd_stb),
    .reg_rd_data        (reg_rd_data),
    .rx_pending_vector  (rx_pending_vector),
    .host_fault_irq     (host_fault_irq),
    .counter_irq        (counter_irq),
    .mac_irq            (mac_irq),
    .rx_filter_enable   (rx_filter_enable),
    .addr_chan_enable   (addr_chan_enable),
    .addr_low_byte_chan (addr_low_byte_chan),
    .addr_high_word     (addr_high_word)
  );

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_stb  <= 1'b1;
    @(posedge core_clk);
    reg_wr_stb  <= 1'b0;
    @(negedge core_clk);
  endtask : wr

  // The read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr   <= a;
    reg_rd_stb <= 1'b1;
    @(posedge core_clk);
    reg_rd_stb <= 1'b0;
    @(negedge core_clk);
    chk(reg_rd_data, exp);
  endtask : rd

  task automatic src(input logic [7:0] rx, input logic [1:0] mac);
    @(posedge core_clk);
    rx_pending_vector <= rx;
    host_fault_irq    <= mac[1];
    counter_irq       <= mac[0];
  endtask : src

  // The interrupt output is registered, so it is looked at one edge later.
  task automatic irq_chk(input logic exp);
    @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(mac_irq), 32'(exp));
  endtask : irq_chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(32'(mac_irq), 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    wr(8'h08, 32'hFFFF_FF5A);
    rd(8'h08, 32'h0000_005A);
    wr(8'h08, 32'h0000_0001);
    rd(8'h0C, 32'h0000_005B);
    wr(8'h0C, 32'hFFFF_FF0A);
    rd(8'h08, 32'h0000_0051);
    src(8'hFF, 2'h0);
    irq_chk(1'b1);
    rd(8'h00, 32'h0000_00FF);
    rd(8'h04, 32'h0000_0051);
    rd(8'h20, 32'h0000_5100);
    @(negedge core_clk);
    chk(reg_rd_data, 32'h0000_0000);
    wr(8'h0C, 32'h0000_00FF);
    irq_chk(1'b0);
    rd(8'h04, 32'h0000_0000);
    // Sticky events clear on read and only unmasked ones interrupt.
    src(8'h00, 2'h0);
    rd(8'h24, 32'h0000_00FF);
    rd(8'h24, 32'h0000_0000);
    wr(8'h28, 32'h0000_0008);
    rd(8'h28, 32'h0000_0008);
    src(8'h18, 2'h0);
    src(8'h00, 2'h0);
    irq_chk(1'b1);
    rd(8'h24, 32'h0000_0018);
    irq_chk(1'b0);
    src(8'h00, 2'h3);
    rd(8'h10, 32'h0000_0003);
    rd(8'h14, 32'h0000_0000);
    wr(8'h18, 32'hFFFF_FFFE);
    rd(8'h14, 32'h0000_0002);
    rd(8'h18, 32'h0000_0002);
    wr(8'h1C, 32'h0000_0000);
    rd(8'h14, 32'h0000_0002);
    wr(8'h18, 32'h0000_0001);
    rd(8'h1C, 32'h0000_0003);
    rd(8'h20, 32'h0003_0000);
    wr(8'h1C, 32'h0000_0002);
    rd(8'h14, 32'h0000_0001);
    rd(8'h20, 32'h0001_0000);
    irq_chk(1'b1);
    wr(8'h1C, 32'hFFFF_FFFF);
    irq_chk(1'b0);
    src(8'h00, 2'h0);
    rd(8'h10, 32'h0000_0000);
    rd(8'h24, 32'h0000_0300);
    wr(8'h44, 32'hFFFF_FF12);
    chk(32'(addr_low_byte_chan[15:8]), 32'h0000_0012);
    rd(8'h44, 32'h0000_0012);
    wr(8'h30, 32'hABCD_0001);
    chk(32'(addr_chan_enable), 32'h0000_0000);
    chk(addr_high_word, 32'hABCD_0000);
    wr(8'h2C, 32'h0000_0002);
    chk(32'(rx_filter_enable), 32'h0000_0002);
    wr(8'h30, 32'hABCD_0001);
    chk(32'(addr_chan_enable), 32'h0000_0002);
    for (int n = 0; n < RX_CHANS; n++) begin
      wr(8'(8'h40 + 4 * n), 32'(n));
    end
    chk(32'(addr_chan_enable), 32'h0000_0000);
    wr(8'h30, 32'h1234_5678);
    chk(32'(addr_chan_enable), 32'h0000_00FF);
    wr(8'h54, 32'h0000_00AA);
    chk(32'(addr_chan_enable), 32'h0000_00DF);
    chk(32'(addr_low_byte_chan[47:40]), 32'h0000_00AA);
    rd(8'h30, 32'h1234_5678);
    // Unmapped writes leave every register alone.
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000);
    rd(8'h2C, 32'h0000_0002);
    rd(8'h08, 32'h0000_0000);
    // A reset in mid-run returns every register to zero.
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(32'(addr_chan_enable), 32'h0000_0000);
    chk(addr_high_word, 32'h0000_0000);
    chk(32'(rx_filter_enable), 32'h0000_0000);
    chk(32'(mac_irq), 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    stop_test();
  end
endmodule : tb_mac_rx_interrupt_mask_status
